// >>> dv/mop_field_model.sv
module mop_field_model
(
	input wire logic clk_sys,
	input wire logic [79:0] cmd_temp,
	input wire logic [9:0] cmd_open,
	input wire logic [15:0] cmd_level,
	input wire logic [15:0] cmd_unbal,
	input wire logic cmd_seq_bad,
	output logic [79:0] sensor_temp,
	output logic [9:0] sensor_open,
	output logic [15:0] i_avg,
	output logic [15:0] i_heat,
	output logic phase_seq_bad_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic churn_reg = 1'b0;

	always @(negedge clk_sys) churn_reg <= ~churn_reg;

	// an open input floats: its reading churns every cycle
	always_comb
	begin
		for (int i = 0; i < 10; i++)
		begin
			if (cmd_open[i])
				sensor_temp[8*i +: 8] = {4{churn_reg, ~churn_reg}};
			else
				sensor_temp[8*i +: 8] = cmd_temp[8*i +: 8];
		end
	end

	assign sensor_open = cmd_open;
	assign i_avg = cmd_level;
	assign i_heat = cmd_level + cmd_unbal;
	assign phase_seq_bad_pin = cmd_seq_bad;
endmodule : mop_field_model

// >>> dv/mop_protect_properties.sv
module mop_protect_properties
#(
	parameter int TICK_CYCLES = 100,
	parameter int PHREV_CYCLES = 200
)
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic variant_ext,
	input wire logic [9:0] sensor_open,
	input wire logic [79:0] sensor_temp,
	input wire mop_pkg::mop_thr_type [9:0] sensor_thr,
	input wire logic open_alert_en,
	input wire logic rtd_bias_en,
	input wire logic motor_running,
	input wire logic phrev_en,
	input wire logic phase_seq_bad_pin,
	input wire logic [9:0] sensor_absent_indication,
	input wire logic [9:0] sensor_alarm,
	input wire logic [9:0] sensor_trip,
	input wire logic open_alert,
	input wire logic [23:0] thermal_capacity,
	input wire logic overload_trip,
	input wire logic phrev_trip,
	input wire logic alarm_relay,
	input wire logic trip_relay
);
	default clocking dflt_cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	absent_flag_a: assert property (sensor_absent_indication[0] == sensor_open[0])
		else $error("absent flag differs from open input");
	base_unused_a: assert property ($rose(sensor_trip[8]) |-> $past(variant_ext))
		else $error("sensor 8 tripped on base variant");
	trip_set_a: assert property (ce && !sensor_open[0]
		&& sensor_thr[0].trip != 8'hff && sensor_temp[7:0] > sensor_thr[0].trip
		|=> sensor_trip[0]) else $error("trip latch missed a hot sensor");
	hyst_hold_a: assert property (sensor_trip[0] && !sensor_open[0]
		&& sensor_thr[0].trip != 8'hff && ({1'b0, sensor_temp[7:0]}
		+ mop_pkg::HYST_C > {1'b0, sensor_thr[0].trip}) |=> sensor_trip[0])
		else $error("trip released inside hysteresis");
	open_alert_a: assert property (open_alert_en && sensor_open[0]
		&& sensor_thr[0] != 16'hffff |-> open_alert && trip_relay)
		else $error("open sensor alert missing");
	alert_off_a: assert property (!open_alert_en |-> !open_alert)
		else $error("open alert while disabled");
	alarm_relay_a: assert property (|sensor_alarm |-> alarm_relay)
		else $error("alarm relay not driven");
	overload_set_a: assert property (ce && !rtd_bias_en
		&& thermal_capacity >= mop_pkg::CAP_FULL |=> overload_trip && trip_relay)
		else $error("overload trip missed at full usage");
	phrev_gate_a: assert property ($rose(phrev_trip) |-> $past(phrev_en))
		else $error("phase reversal trip while disabled");
	phrev_win_a: assert property ($rose(motor_running) && phrev_en
		&& phase_seq_bad_pin ##1 (phrev_en && phase_seq_bad_pin)[*3]
		|-> ##[0:3] phrev_trip) else $error("phase reversal trip late");
endmodule : mop_protect_properties

bind mop_protect mop_protect_properties #(.TICK_CYCLES(TICK_CYCLES),
	.PHREV_CYCLES(PHREV_CYCLES)) chk_u (.clk_sys, .sys_rst, .ce, .variant_ext,
	.sensor_open, .sensor_temp, .sensor_thr, .open_alert_en, .rtd_bias_en,
	.motor_running, .phrev_en, .phase_seq_bad_pin, .sensor_absent_indication,
	.sensor_alarm, .sensor_trip, .open_alert, .thermal_capacity,
	.overload_trip, .phrev_trip, .alarm_relay, .trip_relay);

// >>> dv/mop_protect_tb_top.sv
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module mop_protect_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TICK = 100;
	logic clk_sys, sys_rst, ce, variant_ext, open_alert_en, ambient_en;
	logic reset_req, motor_running, unbal_en, rtd_bias_en, tc_clear;
	logic user_curve_sel, bp_wr_en, phrev_en, phase_seq_bad_pin, cmd_seq_bad;
	logic open_alert, overload_trip, phrev_trip, alarm_relay, trip_relay;
	logic [9:0] sensor_open, cmd_open, sensor_absent_indication;
	logic [9:0] sensor_alarm, sensor_trip;
	logic [79:0] sensor_temp, cmd_temp, sensor_reading;
	logic [15:0] i_avg, i_heat, cmd_level, cmd_unbal, bp_rd_time;
	logic [6:0] tc_avail_pct;
	logic [2:0] std_curve_sel;
	logic [4:0] bp_rd_idx;
	logic [23:0] thermal_capacity;
	mop_pkg::mop_thr_type [9:0] sensor_thr;
	mop_pkg::mop_bp_type bp_wr;
	int n_errors = 0;
	int compares = 0;

	mop_protect #(.TICK_CYCLES(TICK), .PHREV_CYCLES(200)) dut_u (.clk_sys,
		.sys_rst, .ce, .variant_ext, .sensor_open, .sensor_temp, .sensor_thr,
		.open_alert_en, .ambient_en, .reset_req, .motor_running, .i_avg,
		.i_heat, .unbal_en, .rtd_bias_en, .tc_avail_pct, .tc_clear,
		.std_curve_sel, .user_curve_sel, .bp_wr_en, .bp_wr, .bp_rd_idx,
		.phrev_en, .phase_seq_bad_pin, .sensor_reading,
		.sensor_absent_indication, .sensor_alarm, .sensor_trip, .open_alert,
		.thermal_capacity, .overload_trip, .phrev_trip, .bp_rd_time,
		.alarm_relay, .trip_relay);
	mop_field_model field_u (.clk_sys, .cmd_temp, .cmd_open, .cmd_level,
		.cmd_unbal, .cmd_seq_bad, .sensor_temp, .sensor_open, .i_avg, .i_heat,
		.phase_seq_bad_pin);

	////////////////////////////////////////////////////////////////////////
	task cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : cyc

	task pulse_reset();
		reset_req = 1'b1;
		cyc(1);
		reset_req = 1'b0;
		cyc(1);
	endtask : pulse_reset

	task set_sensor(input int i, input logic [7:0] t, input logic [15:0] thr);
		cmd_temp[8*i +: 8] = t;
		sensor_thr[i] = thr;
		cyc(2);
	endtask : set_sensor

	task t_hyst();
		set_sensor(0, 8'h65, 16'h5a64);
		`CHK({sensor_trip[0], sensor_alarm[0], trip_relay}, 3'h7)
		`CHK(sensor_reading[7:0], 8'h65)
		set_sensor(0, 8'h61, 16'h5a64);
		pulse_reset();
		`CHK(sensor_trip[0], 1'b1)
		set_sensor(0, 8'h60, 16'h5a64);
		pulse_reset();
		`CHK({sensor_trip[0], sensor_alarm[0]}, 2'h1)
		set_sensor(0, 8'h14, 16'hff64);
		pulse_reset();
		set_sensor(0, 8'h65, 16'hff64);
		`CHK({sensor_trip[0], sensor_alarm[0]}, 2'h2)
		set_sensor(0, 8'h14, 16'hffff);
		pulse_reset();
	endtask : t_hyst

	task t_open();
		cmd_open[0] = 1'b1;
		open_alert_en = 1'b1;
		set_sensor(0, 8'h14, 16'hff50);
		`CHK({sensor_absent_indication[0], sensor_reading[7:0]}, 9'h1ff)
		`CHK(sensor_trip[0], 1'b0)
		`CHK({open_alert, trip_relay, alarm_relay}, 3'h7)
		set_sensor(0, 8'h14, 16'hffff);
		`CHK(open_alert, 1'b0)
		open_alert_en = 1'b0;
		set_sensor(0, 8'h14, 16'hff50);
		`CHK(open_alert, 1'b0)
		cmd_open[0] = 1'b0;
		set_sensor(0, 8'h14, 16'hffff);
		`CHK(sensor_absent_indication[0], 1'b0)
	endtask : t_open

	task t_chan();
		set_sensor(8, 8'h78, 16'hff64);
		`CHK(sensor_trip[8], 1'b0)
		variant_ext = 1'b1;
		ambient_en = 1'b1;
		set_sensor(9, 8'h78, 16'hff64);
		`CHK(sensor_trip[9:8], 2'h1)
		ambient_en = 1'b0;
		cyc(2);
		`CHK(sensor_trip[9:8], 2'h3)
		set_sensor(8, 8'h14, 16'hff64);
		set_sensor(9, 8'h14, 16'hff64);
		pulse_reset();
		`CHK(sensor_trip, 10'h000)
	endtask : t_chan

	task ol_run(input logic [2:0] crv, input logic [15:0] lvl,
		input logic [15:0] unb, input logic ub, input logic [6:0] pct,
		input logic [23:0] incr, input logic trp);
		int k;
		std_curve_sel = crv;
		cmd_level = lvl;
		cmd_unbal = unb;
		unbal_en = ub;
		tc_avail_pct = pct;
		rtd_bias_en = (pct != 7'h64);
		cyc(2);
		motor_running = 1'b1;
		for (k = 0; k < 3*TICK && thermal_capacity === 24'h0; k++)
			cyc(1);
		motor_running = 1'b0;
		`CHK(thermal_capacity, incr)
		cyc(2);
		`CHK({overload_trip, trip_relay}, {trp, trp})
		cyc(TICK);
		tc_clear = 1'b1;
		cyc(1);
		tc_clear = 1'b0;
		pulse_reset();
		`CHK({overload_trip, thermal_capacity}, 25'h0)
	endtask : ol_run

	task t_overload();
		ol_run(3'h0, 16'h0064, 16'h02bc, 1'b0, 7'h64, 24'h0, 1'b0);
		ol_run(3'h0, 16'h0352, 16'h0, 1'b0, 7'h64, 24'h640000, 1'b1);
		ol_run(3'h0, 16'h01f4, 16'h0, 1'b0, 7'h64, 24'h215555, 1'b0);
		ol_run(3'h3, 16'h0073, 16'h0, 1'b0, 7'h64, 24'h0014cb, 1'b0);
		ol_run(3'h0, 16'h01f4, 16'h0, 1'b0, 7'h1e, 24'h215555, 1'b1);
		ol_run(3'h0, 16'h0064, 16'h02bc, 1'b1, 7'h64, 24'h640000, 1'b1);
		ol_run(3'h3, 16'h0320, 16'h0, 1'b0, 7'h64, 24'h140000, 1'b0);
		ol_run(3'h7, 16'h0066, 16'h0, 1'b0, 7'h64, 24'h0001ff, 1'b0);
	endtask : t_overload

	task t_user();
		std_curve_sel = 3'h0;
		bp_rd_idx = 5'h00;
		cyc(1);
		user_curve_sel = 1'b1;
		cyc(2);
		`CHK(bp_rd_time, 16'h0355)
		bp_rd_idx = 5'h16;
		cyc(2);
		`CHK(bp_rd_time, 16'h0000)
		bp_wr = {5'h15, 16'h0002};
		bp_wr_en = 1'b1;
		cyc(1);
		bp_wr_en = 1'b0;
		bp_rd_idx = 5'h15;
		cyc(2);
		`CHK(bp_rd_time, 16'h0002)
		ol_run(3'h0, 16'h0320, 16'h0, 1'b0, 7'h64, 24'h320000, 1'b0);
		ol_run(3'h0, 16'h0307, 16'h0, 1'b0, 7'h64, 24'h640000, 1'b1);
		user_curve_sel = 1'b0;
		ol_run(3'h0, 16'h0320, 16'h0, 1'b0, 7'h64, 24'h640000, 1'b1);
		motor_running = 1'b1;
		cyc(1);
		std_curve_sel = 3'h7;
		cyc(2*TICK);
		motor_running = 1'b0;
		`CHK(overload_trip, 1'b1)
		tc_clear = 1'b1;
		cyc(1);
		tc_clear = 1'b0;
		pulse_reset();
	endtask : t_user

	task t_phrev();
		cmd_level = 16'h0;
		cmd_seq_bad = 1'b1;
		cyc(4);
		motor_running = 1'b1;
		cyc(300);
		`CHK(phrev_trip, 1'b0)
		motor_running = 1'b0;
		phrev_en = 1'b1;
		cyc(2);
		motor_running = 1'b1;
		cyc(6);
		`CHK({phrev_trip, trip_relay}, 2'h3)
		motor_running = 1'b0;
		cmd_seq_bad = 1'b0;
		cyc(2);
		pulse_reset();
		`CHK(phrev_trip, 1'b0)
	endtask : t_phrev

	task print_verdict();
		$display("compares=%0d n_errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	initial
	begin
		#(40000 * 100);
		`CHK(1'b0, 1'b1)
		print_verdict();
	end

	initial
	begin
		{sys_rst, ce, variant_ext, open_alert_en, ambient_en} = 5'h18;
		{reset_req, motor_running, unbal_en, rtd_bias_en, tc_clear} = 5'h0;
		{user_curve_sel, bp_wr_en, phrev_en, cmd_seq_bad} = 4'h0;
		{cmd_open, cmd_level, cmd_unbal} = 42'h0;
		cmd_temp = {10{8'h14}};
		sensor_thr = {10{16'hffff}};
		{tc_avail_pct, std_curve_sel, bp_rd_idx} = 15'h3200;
		bp_wr = '0;
		repeat (4) @(posedge clk_sys);
		cyc(1);
		sys_rst = 1'b0;
		t_hyst();
		t_open();
		t_chan();
		t_overload();
		t_user();
		t_phrev();
		print_verdict();
	end
endmodule : mop_protect_tb_top

// >>> logic/mop_div.sv
module mop_div
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic start,
	input wire logic [23:0] dividend,
	input wire logic [15:0] divisor,
	output logic done,
	output logic [23:0] quotient
);

	logic [15:0] rem_reg;
	logic [23:0] quo_reg;
	logic [4:0] cnt_reg;
	logic done_reg;
	logic [16:0] shifted;
	logic fits;

	assign shifted = {rem_reg, quo_reg[23]};
	assign fits = shifted >= {1'b0, divisor};
	assign done = done_reg;
	assign quotient = quo_reg;

	////////////////////////////////////////////////////////////////////////
	// restoring division, one quotient bit a cycle
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rem_reg <= 16'h0000;
			quo_reg <= 24'h000000;
			cnt_reg <= 5'h00;
			done_reg <= 1'b0;
		end
		else if (ce)
		begin
			done_reg <= 1'b0;
			if (start)
			begin
				rem_reg <= 16'h0000;
				quo_reg <= dividend;
				cnt_reg <= mop_pkg::DIV_STEPS;
			end
			else if (cnt_reg != 5'h00)
			begin
				if (fits)
					rem_reg <= 16'(shifted - {1'b0, divisor});
				else
					rem_reg <= shifted[15:0];
				quo_reg <= {quo_reg[22:0], fits};
				cnt_reg <= 5'(cnt_reg - 5'h01);
				done_reg <= cnt_reg == 5'h01;
			end
		end
	end

endmodule : mop_div

// >>> logic/mop_pkg.sv
package mop_pkg;

	////////////////////////////////////////////////////////////////////////
	// sizes
	localparam int N_SENS = 10;
	localparam int N_BASE = 8;
	localparam int N_BP = 22;
	localparam int N_CURVE = 8;

	////////////////////////////////////////////////////////////////////////
	// temperature coding, degrees c
	localparam logic [7:0] THR_OFF = 8'hff;
	localparam logic [7:0] ABSENT_CODE = 8'hff;
	localparam logic [8:0] HYST_C = 9'h004;
	localparam logic [3:0] LAST_BASE = 4'h7;
	localparam logic [3:0] LAST_EXT = 4'h9;

	////////////////////////////////////////////////////////////////////////
	// overload model, level in hundredths of full load
	localparam logic [15:0] LEVEL_FLC = 16'h0064;
	localparam logic [2:0] CURVE_DEFAULT = 3'h3;
	localparam int CAP_FRAC = 16;
	localparam logic [23:0] CAP_FULL = 24'h640000;
	localparam logic [6:0] PCT_FULL = 7'h64;
	localparam logic [4:0] BP_LAST = 5'h15;
	localparam logic [4:0] BP_SEG_LAST = 5'h14;
	localparam logic [4:0] DIV_STEPS = 5'h18;

	////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_HZ = 10_000_000;
	localparam int TICK_S = 1;
	localparam int TICK_CYCLES = TICK_S * CLK_HZ;
	localparam int PHREV_MS = 3500;
	localparam int PHREV_CYCLES = PHREV_MS * (CLK_HZ / 1000);

	////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic [7:0] alarm;
		logic [7:0] trip;
	} mop_thr_type;

	typedef struct packed {
		logic [4:0] idx;
		logic [15:0] time_s;
	} mop_bp_type;

	typedef struct packed {
		logic alarm;
		logic trip;
		logic absent;
		logic open_alert;
	} mop_chan_type;

endpackage : mop_pkg

// >>> logic/mop_protect.sv
// Notes on behaviour
// - eight sensors base, ten extended; spare ones do general monitoring
// - each sensor has own alarm and trip level, each can be off
// - open or damaged sensor reports an absent marker instead of reading
// - open sensor alert, if enabled, trips unless both levels are off
// - latched sensor alarm and trip outputs release only once temperature is 4 c below level
// - last sensor becomes ambient only when its setting selects that
// - overload curve active only above full load; capacity then consumed
// - overload trip output set when thermal capacity is exhausted
// - unbalance, when enabled, consumes extra capacity; temperature bias, when enabled, lowers the trip limit
// - eight standard curves selectable by curve number
// - user select no uses standard curve, yes uses breakpoints on extended variant only
// - choosing yes shows chosen standard curve breakpoints for reading
// - extended variant takes 22 breakpoints, forms continuous curve
// - breakpoint time above previous level's time inserts a step
// - curve changes made while running take effect at motor stop
// - standard trip times 1.05 to 8.00 full load; default curve 4
// - phase reversal protection enabled by a setting
// - reversed phases at start trip within 3.5 seconds
// - readings from a disconnected sensor are ignored by protection
// - overload trip when usage reaches full thermal capacity, or tc_avail_pct of it when temperature bias is on
module mop_protect
#(
	parameter int TICK_CYCLES = mop_pkg::TICK_CYCLES,
	parameter int PHREV_CYCLES = mop_pkg::PHREV_CYCLES
)
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic variant_ext,
	input wire logic [9:0] sensor_open,
	input wire logic [79:0] sensor_temp,
	input wire mop_pkg::mop_thr_type [9:0] sensor_thr,
	input wire logic open_alert_en,
	input wire logic ambient_en,
	input wire logic reset_req,
	input wire logic motor_running,
	input wire logic [15:0] i_avg,
	input wire logic [15:0] i_heat,
	input wire logic unbal_en,
	input wire logic rtd_bias_en,
	input wire logic [6:0] tc_avail_pct,
	input wire logic tc_clear,
	input wire logic [2:0] std_curve_sel,
	input wire logic user_curve_sel,
	input wire logic bp_wr_en,
	input wire mop_pkg::mop_bp_type bp_wr,
	input wire logic [4:0] bp_rd_idx,
	input wire logic phrev_en,
	input wire logic phase_seq_bad_pin,
	output logic [79:0] sensor_reading,
	output logic [9:0] sensor_absent_indication,
	output logic [9:0] sensor_alarm,
	output logic [9:0] sensor_trip,
	output logic open_alert,
	output logic [23:0] thermal_capacity,
	output logic overload_trip,
	output logic phrev_trip,
	output logic [15:0] bp_rd_time,
	output logic alarm_relay,
	output logic trip_relay
);

	////////////////////////////////////////////////////////////////////////
	// standard curve table
	localparam logic [15:0] LEVEL [0:21] = '{
		105, 110, 120, 130, 140, 150, 175, 200, 225, 250, 275,
		300, 350, 400, 450, 500, 550, 600, 650, 700, 750, 800};
	localparam logic [15:0] STD_TIME [0:7][0:21] = '{
		'{853, 416, 198, 126, 91, 70, 42, 29, 21, 16, 13,
			10, 7, 5, 4, 3, 2, 2, 2, 1, 1, 1},
		'{1707, 833, 397, 253, 182, 140, 84, 58, 43, 33, 26,
			21, 15, 11, 9, 7, 5, 5, 4, 3, 3, 2},
		'{2560, 1250, 596, 380, 273, 210, 127, 87, 64, 50, 39,
			32, 23, 17, 13, 10, 8, 7, 6, 5, 4, 4},
		'{3414, 1666, 795, 507, 364, 280, 169, 116, 86, 66, 53,
			43, 31, 23, 18, 14, 11, 10, 8, 7, 6, 5},
		'{5975, 2916, 1392, 887, 638, 490, 297, 204, 150, 116, 93,
			76, 54, 40, 31, 25, 20, 17, 14, 12, 11, 9},
		'{7682, 3750, 1789, 1141, 820, 630, 381, 262, 193, 150, 119,
			98, 69, 52, 40, 32, 26, 22, 19, 16, 14, 12},
		'{10243, 5000, 2386, 1521, 1093, 840, 509, 350, 258, 200, 159,
			131, 93, 69, 54, 43, 35, 30, 25, 21, 19, 16},
		'{12804, 6250, 2982, 1902, 1367, 1050, 636, 437, 323, 250, 199,
			164, 116, 87, 68, 54, 44, 37, 31, 27, 23, 20}};

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_SEARCH = 5'h02,
		ST_INTERP = 5'h04,
		ST_RATE = 5'h08,
		ST_ACC = 5'h10
	} mop_st_type;

	////////////////////////////////////////////////////////////////////////
	// declarations
	mop_st_type state_reg;
	logic [15:0] pend_tab [0:21];
	logic [15:0] act_tab [0:21];
	logic [2:0] act_curve_reg;
	logic act_user_reg;
	logic user_sel_q_reg;
	logic [15:0] bp_rd_reg;
	logic [23:0] tick_cnt_reg;
	logic tick;
	logic [15:0] x_reg;
	logic [4:0] seg_reg;
	logic [15:0] t_lo_reg;
	logic [23:0] usage_reg;
	logic ol_trip_reg;
	logic [23:0] div_a_reg;
	logic [15:0] div_b_reg;
	logic div_go_reg;
	logic div_done;
	logic [23:0] div_q;
	logic [4:0] seg;
	logic [15:0] t_lo;
	logic [15:0] t_hi;
	logic [15:0] x_now;
	logic [31:0] interp_prod;
	logic [15:0] t_interp;
	logic [24:0] usage_sum;
	logic [23:0] limit;
	logic user_ok;
	logic [9:0] chan_en;
	logic [3:0] last_idx;
	mop_pkg::mop_chan_type [9:0] flags;
	logic seq_s1_reg;
	logic seq_s2_reg;
	logic run_q_reg;
	logic [25:0] phrev_cnt_reg;
	logic phrev_reg;

	////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [4:0] seg_of(input logic [15:0] x);
		logic [4:0] s;
		s = 5'h00;
		for (int i = 1; i < mop_pkg::N_BP - 1; i++)
			if (x >= LEVEL[i])
				s = 5'(i);
		return s;
	endfunction : seg_of

	function automatic logic [15:0] t_at(input logic [4:0] idx);
		logic [15:0] t;
		t = act_user_reg ? act_tab[idx] : STD_TIME[act_curve_reg][idx];
		return (t == 16'h0000) ? 16'h0001 : t;
	endfunction : t_at

	////////////////////////////////////////////////////////////////////////
	// sensor channels
	assign last_idx = variant_ext ? mop_pkg::LAST_EXT : mop_pkg::LAST_BASE;

	always_comb
	begin
		for (int i = 0; i < mop_pkg::N_SENS; i++)
			chan_en[i] = ((i < mop_pkg::N_BASE) | variant_ext) &
				~(ambient_en & (4'(i) == last_idx));
	end

	for (genvar g = 0; g < mop_pkg::N_SENS; g++)
	begin : g_chan
		mop_rtd_chan u_chan
		(
			.clk_sys(clk_sys),
			.sys_rst(sys_rst),
			.ce(ce),
			.chan_en(chan_en[g]),
			.sensor_open(sensor_open[g]),
			.temp(sensor_temp[g*8 +: 8]),
			.thr(sensor_thr[g]),
			.reset_req(reset_req),
			.flags(flags[g]),
			.reading(sensor_reading[g*8 +: 8])
		);
		assign sensor_absent_indication[g] = flags[g].absent;
		assign sensor_alarm[g] = flags[g].alarm;
		assign sensor_trip[g] = flags[g].trip;
	end

	always_comb
	begin
		open_alert = 1'b0;
		for (int i = 0; i < mop_pkg::N_SENS; i++)
			open_alert = open_alert | (open_alert_en & flags[i].open_alert);
	end

	////////////////////////////////////////////////////////////////////////
	// curve settings, pending and active
	assign user_ok = user_curve_sel & variant_ext;

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			user_sel_q_reg <= 1'b0;
			bp_rd_reg <= 16'h0000;
			for (int i = 0; i < mop_pkg::N_BP; i++)
				pend_tab[i] <= STD_TIME[mop_pkg::CURVE_DEFAULT][i];
		end
		else if (ce)
		begin
			user_sel_q_reg <= user_ok;
			if (user_ok & ~user_sel_q_reg)
			begin
				for (int i = 0; i < mop_pkg::N_BP; i++)
					pend_tab[i] <= STD_TIME[std_curve_sel][i];
			end
			else if (bp_wr_en & (bp_wr.idx <= mop_pkg::BP_LAST))
				pend_tab[bp_wr.idx] <= bp_wr.time_s;
			if (bp_rd_idx <= mop_pkg::BP_LAST)
				bp_rd_reg <= pend_tab[bp_rd_idx];
			else
				bp_rd_reg <= 16'h0000;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			act_curve_reg <= mop_pkg::CURVE_DEFAULT;
			act_user_reg <= 1'b0;
			for (int i = 0; i < mop_pkg::N_BP; i++)
				act_tab[i] <= STD_TIME[mop_pkg::CURVE_DEFAULT][i];
		end
		else if (ce & ~motor_running)
		begin
			act_curve_reg <= std_curve_sel;
			act_user_reg <= user_ok;
			for (int i = 0; i < mop_pkg::N_BP; i++)
				act_tab[i] <= pend_tab[i];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// one second tick
	assign tick = tick_cnt_reg == 24'(TICK_CYCLES - 1);

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			tick_cnt_reg <= 24'h000000;
		else if (ce)
			tick_cnt_reg <= tick ? 24'h000000 : 24'(tick_cnt_reg + 24'h000001);
	end

	////////////////////////////////////////////////////////////////////////
	// overload curve evaluation
	assign x_now = unbal_en ? i_heat : i_avg;
	assign seg = seg_of(x_reg);
	// a process, so a change of the active curve is seen at once
	always_comb
	begin
		t_lo = t_at(seg);
		t_hi = t_at(5'(seg + 5'h01));
	end
	assign interp_prod = 32'(t_lo - t_hi) * 32'(x_reg - LEVEL[seg]);
	assign t_interp = 16'(t_lo_reg - div_q[15:0]);
	assign usage_sum = {1'b0, usage_reg} + {1'b0, div_q};
	assign limit = (rtd_bias_en & (tc_avail_pct < mop_pkg::PCT_FULL)) ?
		{1'b0, tc_avail_pct, 16'h0000} : mop_pkg::CAP_FULL;

	mop_div u_div
	(
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.ce(ce),
		.start(div_go_reg),
		.dividend(div_a_reg),
		.divisor(div_b_reg),
		.done(div_done),
		.quotient(div_q)
	);

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_reg <= ST_IDLE;
			x_reg <= 16'h0000;
			seg_reg <= 5'h00;
			t_lo_reg <= 16'h0001;
			div_a_reg <= 24'h000000;
			div_b_reg <= 16'h0001;
			div_go_reg <= 1'b0;
		end
		else if (ce)
		begin
			div_go_reg <= 1'b0;
			case (state_reg)
				ST_IDLE:
				begin
					if (tick & motor_running & (x_now > mop_pkg::LEVEL_FLC))
					begin
						x_reg <= x_now;
						state_reg <= ST_SEARCH;
					end
				end
				ST_SEARCH:
				begin
					seg_reg <= seg;
					t_lo_reg <= t_lo;
					if ((x_reg <= LEVEL[0]) | (x_reg >= LEVEL[mop_pkg::BP_LAST]) |
						(t_hi > t_lo) | (t_hi == t_lo))
					begin
						div_a_reg <= mop_pkg::CAP_FULL;
						div_b_reg <= (x_reg >= LEVEL[mop_pkg::BP_LAST]) ?
							t_at(mop_pkg::BP_LAST) : t_lo;
						div_go_reg <= 1'b1;
						state_reg <= ST_RATE;
					end
					else
					begin
						div_a_reg <= interp_prod[23:0];
						div_b_reg <= 16'(LEVEL[5'(seg + 5'h01)] - LEVEL[seg]);
						div_go_reg <= 1'b1;
						state_reg <= ST_INTERP;
					end
				end
				ST_INTERP:
				begin
					if (div_done)
					begin
						div_a_reg <= mop_pkg::CAP_FULL;
						div_b_reg <= (t_interp == 16'h0000) ? 16'h0001 : t_interp;
						div_go_reg <= 1'b1;
						state_reg <= ST_RATE;
					end
				end
				ST_RATE:
				begin
					if (div_done)
						state_reg <= ST_ACC;
				end
				ST_ACC:
				begin
					state_reg <= ST_IDLE;
				end
				default:
				begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// thermal usage and overload trip
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			usage_reg <= 24'h000000;
		else if (ce)
		begin
			if (state_reg == ST_ACC)
				usage_reg <= usage_sum[24] ? 24'hffffff : usage_sum[23:0];
			else if (tc_clear)
				usage_reg <= 24'h000000;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			ol_trip_reg <= 1'b0;
		else if (ce)
		begin
			if (usage_reg >= limit)
				ol_trip_reg <= 1'b1;
			else if (reset_req)
				ol_trip_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// phase reversal at start
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			seq_s1_reg <= 1'b0;
			seq_s2_reg <= 1'b0;
			run_q_reg <= 1'b0;
			phrev_cnt_reg <= 26'h0000000;
			phrev_reg <= 1'b0;
		end
		else if (ce)
		begin
			seq_s1_reg <= phase_seq_bad_pin;
			seq_s2_reg <= seq_s1_reg;
			run_q_reg <= motor_running;
			if (motor_running & ~run_q_reg)
				phrev_cnt_reg <= 26'(PHREV_CYCLES);
			else if (phrev_cnt_reg != 26'h0000000)
				phrev_cnt_reg <= 26'(phrev_cnt_reg - 26'h0000001);
			if (phrev_en & motor_running & (phrev_cnt_reg != 26'h0000000) &
				seq_s2_reg)
				phrev_reg <= 1'b1;
			else if (reset_req & ~motor_running)
				phrev_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign thermal_capacity = usage_reg;
	assign overload_trip = ol_trip_reg;
	assign phrev_trip = phrev_reg;
	assign bp_rd_time = bp_rd_reg;
	assign alarm_relay = (|sensor_alarm) | open_alert;
	assign trip_relay = (|sensor_trip) | ol_trip_reg | phrev_reg | open_alert;

endmodule : mop_protect

// >>> logic/mop_rtd_chan.sv
module mop_rtd_chan
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic chan_en,
	input wire logic sensor_open,
	input wire logic [7:0] temp,
	input wire mop_pkg::mop_thr_type thr,
	input wire logic reset_req,
	output mop_pkg::mop_chan_type flags,
	output logic [7:0] reading
);

	logic live;
	logic alarm_on;
	logic trip_on;
	logic alarm_hit;
	logic trip_hit;
	logic alarm_clr_ok;
	logic trip_clr_ok;
	logic alarm_reg;
	logic trip_reg;
	logic [7:0] reading_reg;

	assign live = chan_en & ~sensor_open;
	assign alarm_on = thr.alarm != mop_pkg::THR_OFF;
	assign trip_on = thr.trip != mop_pkg::THR_OFF;
	assign alarm_hit = live & alarm_on & (temp > thr.alarm);
	assign trip_hit = live & trip_on & (temp > thr.trip);
	// release only 4 c below the exceeded level
	assign alarm_clr_ok = ~live |
		(({1'b0, temp} + mop_pkg::HYST_C) <= {1'b0, thr.alarm});
	assign trip_clr_ok = ~live |
		(({1'b0, temp} + mop_pkg::HYST_C) <= {1'b0, thr.trip});

	////////////////////////////////////////////////////////////////////////
	// latched alarm and trip, a new hit wins over a reset
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			alarm_reg <= 1'b0;
			trip_reg <= 1'b0;
		end
		else if (ce)
		begin
			if (alarm_hit)
				alarm_reg <= 1'b1;
			else if (reset_req & alarm_clr_ok)
				alarm_reg <= 1'b0;
			if (trip_hit)
				trip_reg <= 1'b1;
			else if (reset_req & trip_clr_ok)
				trip_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// readout with absent marker
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			reading_reg <= mop_pkg::ABSENT_CODE;
		else if (ce)
			reading_reg <= sensor_open ? mop_pkg::ABSENT_CODE : temp;
	end

	assign reading = reading_reg;
	assign flags.alarm = alarm_reg;
	assign flags.trip = trip_reg;
	assign flags.absent = chan_en & sensor_open;
	assign flags.open_alert = chan_en & sensor_open & (alarm_on | trip_on);

endmodule : mop_rtd_chan
